// ==== logic/trc_row_combine.sv ====
// exposure timing and two-row combination of a dual-row tdi line sensor, ahb-lite register slave
// Operation
// - in summing operation one output line per trigger carries the per-pixel sum of both rows.
// - as an alternative the output line carries the per-pixel average of both rows.
// - a new exposure may integrate while readout of an earlier one is still running.
// - on the 4k sensor only one row is read at any time, never both together.
// - in programmable exposure modes the sensor pulse is shortened by the 3.2 us overhead.
// - in trigger-width mode the trigger pulse goes to the sensor unchanged.
// - on the 2k sensor both rows start and end exposure at the same moment.
// - on the 4k sensor row two is staggered by half the previous line period by default.
// - with the short option row two is delayed by a fixed 15 us instead.
// - effective integration time is the line period times two stages.
// - in single-row operation exactly one row is output per line trigger.
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "trc_map.svh"
module trc_row_combine #(
  parameter int PIX_W = 12,
  parameter int CW = 24
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write strobe
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // response
  input wire logic external_line_trigger, // line trigger pin
  output logic row1_expose, // row one exposure pulse
  output logic row2_expose, // row two exposure pulse
  output logic [1:0] pix_row_sel, // rows being read, bit0 row one
  input wire logic pix_valid, // sensor pixel strobe
  input wire logic [PIX_W-1:0] pix_row1, // row one pixel
  input wire logic [PIX_W-1:0] pix_row2, // row two pixel
  input wire logic pix_last, // last pixel of line
  output logic out_valid, // output pixel strobe
  output logic [PIX_W-1:0] out_data, // output pixel
  output logic out_last // last pixel of output line
);
  import trc_pkg::*;

  localparam int OVH_CYC = `TRC_OVH_NS / `TRC_CLK_NS;
  localparam int SHORT_CYC = `TRC_SHORT_NS / `TRC_CLK_NS;
  localparam logic [CW-1:0] OVH = CW'(OVH_CYC);
  localparam logic [CW-1:0] SHORT = CW'(SHORT_CYC);
  localparam logic [CW-1:0] ONE = CW'(1);
  localparam logic [PIX_W:0] PMAX = {1'b0, {PIX_W{1'b1}}};

  // ==========================================================================
  // register bus
  logic [7:0] ctrl_reg;
  logic [CW-1:0] expo_reg;
  logic [CW-1:0] period_reg;
  logic [CW-1:0] meas_reg;
  logic [CW-1:0] lines_reg;
  logic [7:0] wa_reg;
  logic wr_reg;
  logic [31:0] rdata_reg;
  wire take = hsel && htrans[1] && hready;
  wire wr_ctrl = wr_reg && wa_reg == `TRC_OFS_CTRL;
  wire wr_expo = wr_reg && wa_reg == `TRC_OFS_EXPO;
  wire wr_period = wr_reg && wa_reg == `TRC_OFS_PERIOD;
  wire acq_en = ctrl_reg[`TRC_CTRL_ACQ_EN];
  wire trig_ext = ctrl_reg[`TRC_CTRL_TRIG_EXT];
  wire sel_4k = ctrl_reg[`TRC_CTRL_SENSOR_4K];
  wire short_dly = ctrl_reg[`TRC_CTRL_SHORT_DLY];
  wire trc_mode_e mode = trc_mode_e'(ctrl_reg[`TRC_CTRL_MODE_LSB +: 2]);
  wire trc_expo_e xmode = trc_expo_e'(ctrl_reg[`TRC_CTRL_EXPO_LSB +: 2]);
  wire [31:0] integ = {{(31-CW){1'b0}}, meas_reg, 1'b0};
  wire [31:0] status;
  wire [31:0] rd_mux =
    haddr == `TRC_OFS_CTRL ? {24'h0, ctrl_reg} :
    haddr == `TRC_OFS_EXPO ? {{(32-CW){1'b0}}, expo_reg} :
    haddr == `TRC_OFS_PERIOD ? {{(32-CW){1'b0}}, period_reg} :
    haddr == `TRC_OFS_STATUS ? status :
    haddr == `TRC_OFS_MEAS ? {{(32-CW){1'b0}}, meas_reg} :
    haddr == `TRC_OFS_INTEG ? integ :
    haddr == `TRC_OFS_LINES ? {{(32-CW){1'b0}}, lines_reg} : 32'h0;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'b0;
      wa_reg <= 8'h00;
      rdata_reg <= 32'h0;
    end else if (ce) begin
      wr_reg <= take && hwrite;
      wa_reg <= haddr;
      rdata_reg <= (take && !hwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `TRC_CTRL_RST;
      expo_reg <= CW'(`TRC_EXPO_RST);
      period_reg <= CW'(`TRC_PERIOD_RST);
    end else if (ce) begin
      if (wr_ctrl) ctrl_reg <= hwdata[7:0];
      if (wr_expo) expo_reg <= hwdata[CW-1:0];
      if (wr_period) period_reg <= hwdata[CW-1:0];
    end
  end

  // ==========================================================================
  // trigger source
  logic trg_s1_reg;
  logic trg_s2_reg;
  logic trg_d_reg;
  logic [CW-1:0] tmr_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trg_s1_reg <= 1'b0;
      trg_s2_reg <= 1'b0;
      trg_d_reg <= 1'b0;
      tmr_reg <= '0;
    end else if (ce) begin
      trg_s1_reg <= external_line_trigger;
      trg_s2_reg <= trg_s1_reg;
      trg_d_reg <= trg_s2_reg;
      tmr_reg <= (!acq_en || tmr_reg >= period_reg - ONE) ? '0 : tmr_reg + ONE;
    end
  end
  wire tmr_fire = acq_en && !trig_ext && tmr_reg == '0;
  wire ext_fire = acq_en && trig_ext && trg_s2_reg && !trg_d_reg;
  wire fire = tmr_fire || ext_fire;
  wire pw_mode = trig_ext && xmode == TRC_EXP_WIDTH;
  // sensor adds the overhead itself, so the drive pulse is shorter by that much
  wire [CW-1:0] prog_len = (expo_reg > OVH + ONE) ? expo_reg - OVH : ONE;

  // ==========================================================================
  // row one exposure and line period measure
  logic row1_on_reg;
  logic [CW-1:0] row1_cnt_reg;
  logic [CW-1:0] row1_len_reg;
  logic [CW-1:0] per_cnt_reg;
  wire row1_start = pw_mode ? (acq_en && trg_s2_reg && !row1_on_reg) : (fire && !row1_on_reg);
  wire row1_stop = pw_mode ? !(acq_en && trg_s2_reg) : row1_cnt_reg == ONE;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row1_on_reg <= 1'b0;
      row1_cnt_reg <= '0;
      row1_len_reg <= '0;
      per_cnt_reg <= '0;
      meas_reg <= '0;
    end else if (ce) begin
      per_cnt_reg <= row1_start ? ONE : per_cnt_reg + ONE;
      if (row1_start) meas_reg <= per_cnt_reg;
      if (row1_start) begin
        row1_on_reg <= 1'b1;
        row1_cnt_reg <= prog_len;
      end else if (row1_on_reg && row1_stop) begin
        row1_on_reg <= 1'b0;
        row1_len_reg <= row1_cnt_reg;
      end else if (row1_on_reg) begin
        row1_cnt_reg <= row1_cnt_reg - ONE;
      end
    end
  end
  // in width mode the counter runs down from prog_len, so the length seen is prog_len minus the count left, plus one
  wire [CW-1:0] row1_width = pw_mode ? prog_len - row1_len_reg + ONE : prog_len;

  // ==========================================================================
  // row two staggered exposure on the 4k sensor
  logic dly_on_reg;
  logic [CW-1:0] dly_cnt_reg;
  logic row2_on_reg;
  logic [CW-1:0] row2_cnt_reg;
  // the running start-to-start count is the period that has just ended, not the stale measurement
  wire [CW-1:0] half = (per_cnt_reg > ONE) ? {1'b0, per_cnt_reg[CW-1:1]} : ONE;
  wire [CW-1:0] dly_load = short_dly ? SHORT : half;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_on_reg <= 1'b0;
      dly_cnt_reg <= '0;
      row2_on_reg <= 1'b0;
      row2_cnt_reg <= '0;
    end else if (ce) begin
      if (row1_start && sel_4k) begin
        dly_on_reg <= 1'b1;
        dly_cnt_reg <= dly_load;
      end else if (dly_on_reg) begin
        dly_cnt_reg <= dly_cnt_reg - ONE;
        dly_on_reg <= dly_cnt_reg != ONE;
      end
      if (dly_on_reg && dly_cnt_reg == ONE) begin
        row2_on_reg <= 1'b1;
        row2_cnt_reg <= (row1_width > '0) ? row1_width : ONE;
      end else if (row2_on_reg) begin
        row2_cnt_reg <= row2_cnt_reg - ONE;
        row2_on_reg <= row2_cnt_reg != ONE;
      end
    end
  end
  assign row1_expose = row1_on_reg;
  assign row2_expose = sel_4k ? row2_on_reg : row1_on_reg;

  // ==========================================================================
  // readout and row combination, independent of the exposure logic
  trc_rd_e ph_reg;
  logic [PIX_W-1:0] hold_reg;
  logic [PIX_W-1:0] odata_reg;
  logic ovalid_reg;
  logic olast_reg;
  wire dual = mode != TRC_SINGLE;
  wire [PIX_W-1:0] rowa = sel_4k ? hold_reg : pix_row1;
  wire [PIX_W:0] sum = {1'b0, rowa} + {1'b0, pix_row2};
  wire [PIX_W-1:0] sat = (sum > PMAX) ? {PIX_W{1'b1}} : sum[PIX_W-1:0];
  wire [PIX_W-1:0] avg = sum[PIX_W:1];
  wire [PIX_W-1:0] comb = (mode == TRC_AVG) ? avg : sat;
  wire emit = pix_valid && (!dual || !sel_4k || ph_reg == TRC_RD_ROW2);
  assign pix_row_sel = !dual ? 2'b01 : !sel_4k ? 2'b11 : (ph_reg == TRC_RD_ROW2 ? 2'b10 : 2'b01);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_reg <= TRC_RD_ROW1;
      hold_reg <= '0;
      odata_reg <= '0;
      ovalid_reg <= 1'b0;
      olast_reg <= 1'b0;
      lines_reg <= '0;
    end else if (ce) begin
      ovalid_reg <= emit;
      olast_reg <= emit && pix_last;
      if (emit) odata_reg <= dual ? comb : pix_row1;
      if (emit && pix_last) lines_reg <= lines_reg + ONE;
      case (ph_reg)
        TRC_RD_ROW1: begin
          if (pix_valid && dual && sel_4k) begin
            hold_reg <= pix_row1;
            ph_reg <= TRC_RD_ROW2;
          end
        end
        TRC_RD_ROW2: begin
          if (pix_valid || !dual || !sel_4k) ph_reg <= TRC_RD_ROW1;
        end
        default: ph_reg <= TRC_RD_ROW1;
      endcase
    end
  end
  assign out_valid = ovalid_reg;
  assign out_data = odata_reg;
  assign out_last = olast_reg;
  assign status = {28'h0, ph_reg, dly_on_reg, row2_expose, row1_expose};

  // ==========================================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_one_row_4k;
    sel_4k && dual |-> pix_row_sel != 2'b11;
  endproperty
  a_one_row_4k: assert property (p_one_row_4k) else $error("both rows read on 4k");

  property p_sum_sat;
    ce && pix_valid && !sel_4k && mode == TRC_SUM && ({1'b0, pix_row1} + {1'b0, pix_row2}) > PMAX
      |=> out_valid && out_data == {PIX_W{1'b1}};
  endproperty
  a_sum_sat: assert property (p_sum_sat) else $error("sum did not saturate");

  property p_sum;
    ce && pix_valid && !sel_4k && mode == TRC_SUM
      |=> out_data >= $past(pix_row1) && out_data >= $past(pix_row2);
  endproperty
  a_sum: assert property (p_sum) else $error("sum below a row value");

  property p_avg;
    ce && pix_valid && !sel_4k && mode == TRC_AVG
      |=> out_data == PIX_W'(({1'b0, $past(pix_row1)} + {1'b0, $past(pix_row2)}) >> 1);
  endproperty
  a_avg: assert property (p_avg) else $error("average wrong");

  property p_single;
    ce && pix_valid && mode == TRC_SINGLE |=> out_valid && out_data == $past(pix_row1);
  endproperty
  a_single: assert property (p_single) else $error("single row not output");

  property p_concurrent;
    ce && pix_valid && row1_on_reg && mode == TRC_SINGLE |=> out_valid;
  endproperty
  a_concurrent: assert property (p_concurrent) else $error("readout stalled by exposure");

  property p_prog_len;
    ce && row1_start && !pw_mode && expo_reg > OVH + ONE
      |=> row1_on_reg && row1_cnt_reg == $past(expo_reg) - OVH;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("exposure not shortened");

  property p_width;
    ce && pw_mode && row1_on_reg && !(acq_en && trg_s2_reg) |=> !row1_on_reg;
  endproperty
  a_width: assert property (p_width) else $error("width pulse not followed");

  property p_same_2k;
    !sel_4k |-> row2_expose == row1_on_reg;
  endproperty
  a_same_2k: assert property (p_same_2k) else $error("2k rows not together");

  property p_stagger;
    ce && row1_start && sel_4k && (short_dly || per_cnt_reg > ONE)
      |=> dly_on_reg && dly_cnt_reg == ($past(short_dly) ? SHORT : meas_reg >> 1);
  endproperty
  a_stagger: assert property (p_stagger) else $error("row two delay wrong");

  property p_row2_go;
    ce && dly_on_reg && dly_cnt_reg == ONE |=> row2_on_reg;
  endproperty
  a_row2_go: assert property (p_row2_go) else $error("row two exposure did not start");

  property p_sum_4k;
    ce && pix_valid && sel_4k && mode == TRC_SUM && ph_reg == TRC_RD_ROW2 && ({1'b0, hold_reg} + {1'b0, pix_row2}) <= PMAX
      |=> out_valid && out_data == PIX_W'({1'b0, $past(hold_reg)} + {1'b0, $past(pix_row2)});
  endproperty
  a_sum_4k: assert property (p_sum_4k) else $error("4k sum wrong");

  property p_row1_first;
    ce && pix_valid && dual && sel_4k && ph_reg == TRC_RD_ROW1 |=> !out_valid && ph_reg == TRC_RD_ROW2;
  endproperty
  a_row1_first: assert property (p_row1_first) else $error("4k row one not read alone");

  property p_single_last;
    ce && pix_valid && pix_last && mode == TRC_SINGLE |=> out_last && lines_reg == $past(lines_reg) + ONE;
  endproperty
  a_single_last: assert property (p_single_last) else $error("single row line not counted");

  property p_fire;
    ce && fire && !row1_on_reg && !pw_mode |=> row1_expose;
  endproperty
  a_fire: assert property (p_fire) else $error("trigger did not start exposure");

  property p_integ;
    integ == 32'(meas_reg) * 32'd2;
  endproperty
  a_integ: assert property (p_integ) else $error("integration time wrong");
endmodule

// ==== logic/trc_map.svh ====
// register offsets, field positions, reset values and timing figures of the tdi row combiner
`ifndef TRC_MAP_SVH
`define TRC_MAP_SVH
`define TRC_OFS_CTRL 8'h00
`define TRC_OFS_EXPO 8'h04
`define TRC_OFS_PERIOD 8'h08
`define TRC_OFS_STATUS 8'h0c
`define TRC_OFS_MEAS 8'h10
`define TRC_OFS_INTEG 8'h14
`define TRC_OFS_LINES 8'h18
`define TRC_CTRL_ACQ_EN 0
`define TRC_CTRL_TRIG_EXT 1
`define TRC_CTRL_SENSOR_4K 2
`define TRC_CTRL_SHORT_DLY 3
`define TRC_CTRL_MODE_LSB 4
`define TRC_CTRL_EXPO_LSB 6
`define TRC_CTRL_RST 8'h00
`define TRC_EXPO_RST 24'h000fa0
`define TRC_PERIOD_RST 24'h002710
`define TRC_CLK_NS 8
`define TRC_OVH_NS 3200
`define TRC_SHORT_NS 15000
`endif

// ==== logic/trc_pkg.sv ====
// types shared by the tdi row combiner
package trc_pkg;
  typedef enum logic [1:0] {
    TRC_SINGLE = 2'b00,
    TRC_SUM = 2'b01,
    TRC_AVG = 2'b10
  } trc_mode_e;
  typedef enum logic [1:0] {
    TRC_EXP_TIMED = 2'b00,
    TRC_EXP_PROG = 2'b01,
    TRC_EXP_WIDTH = 2'b10
  } trc_expo_e;
  typedef enum logic {
    TRC_RD_ROW1 = 1'b0,
    TRC_RD_ROW2 = 1'b1
  } trc_rd_e;
endpackage

// ==== test/trc_trig_src.sv ====
// external line trigger source locked to object travel
`timescale 1ns/1ps
module trc_trig_src (
  input wire logic clk, // system clock
  input wire logic run, // object moving
  input wire logic [4:0] pitch_um, // travel per trigger
  input wire logic [9:0] cyc_per_um, // cycles per micrometre
  input wire logic [7:0] width, // pulse length in cycles
  output logic trig // line trigger pin
);
  int sub = 0;
  int pos = 0;
  int hi = 0;
  // ==========================================
  // one pulse each time the object advances one pitch
  always @(posedge clk) begin
    if (hi > 0) hi <= hi - 1;
    if (!run) begin
      sub <= 0;
      pos <= 0;
    end else if (sub >= cyc_per_um - 1) begin
      sub <= 0;
      if (pos >= pitch_um - 1) begin
        pos <= 0;
        hi <= width;
      end else pos <= pos + 1;
    end else sub <= sub + 1;
  end
  assign trig = hi > 0;
endmodule

// ==== test/tb.sv ====
// self-checking bench of the tdi row combiner
`timescale 1ns/1ps
`include "trc_map.svh"
module tb;
  import trc_pkg::*;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, trig, row1_expose, row2_expose, out_valid, out_last;
  logic [1:0] pix_row_sel;
  logic pix_valid = 0;
  logic pix_last = 0;
  logic [11:0] pix_row1 = 12'h000;
  logic [11:0] pix_row2 = 12'h000;
  logic [11:0] out_data;
  logic run = 0;
  logic [4:0] pitch = 5'd14;
  logic [9:0] cpu = 10'd20;
  logic [7:0] width = 8'd4;
  int failures = 0;
  int n_tests = 0;
  int r1, l1, r2, l2;
  always #4 hclk = ~hclk;
  trc_row_combine uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .external_line_trigger(trig),
    .row1_expose(row1_expose), .row2_expose(row2_expose), .pix_row_sel(pix_row_sel),
    .pix_valid(pix_valid), .pix_row1(pix_row1), .pix_row2(pix_row2), .pix_last(pix_last),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last));
  trc_trig_src src (.clk(hclk), .run(run), .pitch_um(pitch), .cyc_per_um(cpu), .width(width),
    .trig(trig));
  // ==========================================
  // checking and bus tasks
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task summarize;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, input string n, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, q, e);
  endtask
  function logic [31:0] cw(input logic [1:0] ex, input logic [1:0] m, input logic [3:0] f);
    return {24'h0, ex, m, f};
  endfunction
  // start cycle and length of the next pulse on each row
  task automatic expo(output int a1, n1, a2, n2);
    a1 = -1;
    a2 = -1;
    n1 = 0;
    n2 = 0;
    while (row1_expose === 1'b1) @(posedge hclk);
    for (int c = 0; c < 6000; c++) begin
      @(posedge hclk);
      if (row1_expose === 1'b1) begin
        if (a1 < 0) a1 = c;
        n1++;
      end
      if (row2_expose === 1'b1) begin
        if (a2 < 0) a2 = c;
        n2++;
      end
      if (a2 >= 0 && row2_expose !== 1'b1) break;
    end
  endtask
  // one pixel pair; the 4k sensor gets row one then row two
  task px(input logic four, input logic [1:0] sel, input logic [11:0] a, b, e);
    pix_valid <= 1'b1;
    pix_row1 <= a;
    pix_row2 <= b;
    pix_last <= !four;
    @(posedge hclk);
    chk("sel", {30'h0, pix_row_sel}, {30'h0, four ? 2'b01 : sel});
    if (four) begin
      pix_last <= 1'b1;
      @(posedge hclk);
      chk("sel2", {30'h0, pix_row_sel}, 32'h2);
    end
    pix_valid <= 1'b0;
    pix_last <= 1'b0;
    @(posedge hclk);
    chk("out", {18'h0, out_last, out_valid, out_data}, {18'h0, 2'b11, e});
  endtask
  // ==========================================
  // scenarios
  task t_2k;
    wr(`TRC_OFS_EXPO, 32'd410);
    wr(`TRC_OFS_CTRL, cw(TRC_EXP_PROG, TRC_SUM, 4'b0011));
    run <= 1'b1;
    expo(r1, l1, r2, l2);
    chk("len", l1, 410 - `TRC_OVH_NS / `TRC_CLK_NS);
    chk("r2start", r2, r1);
    chk("r2len", l2, l1);
    do @(posedge hclk); while (row1_expose !== 1'b1);
    px(1'b0, 2'b11, 12'd5, 12'd7, 12'd12);
    px(1'b0, 2'b11, 12'hfff, 12'h001, 12'hfff);
    wr(`TRC_OFS_CTRL, cw(TRC_EXP_PROG, TRC_AVG, 4'b0011));
    px(1'b0, 2'b11, 12'd7, 12'd4, 12'd5);
    wr(`TRC_OFS_CTRL, cw(TRC_EXP_PROG, TRC_SINGLE, 4'b0011));
    px(1'b0, 2'b01, 12'h123, 12'h456, 12'h123);
    run <= 1'b0;
  endtask
  task t_width;
    width <= 8'd30;
    wr(`TRC_OFS_CTRL, cw(TRC_EXP_WIDTH, TRC_SUM, 4'b0011));
    run <= 1'b1;
    expo(r1, l1, r2, l2);
    chk("width", l1 >= 27 && l1 <= 31, 1);
    run <= 1'b0;
  endtask
  task t_4k;
    pitch <= 5'd7;
    cpu <= 10'd200;
    wr(`TRC_OFS_EXPO, 32'd100);
    wr(`TRC_OFS_CTRL, cw(TRC_EXP_PROG, TRC_SUM, 4'b0111));
    run <= 1'b1;
    repeat (3) expo(r1, l1, r2, l2);
    chk("half", r2 - r1 >= 698 && r2 - r1 <= 702, 1);
    chk("minlen", l1, 1);
    chk("r2len4k", l2, 1);
    px(1'b1, 2'b00, 12'd9, 12'd3, 12'd12);
    cpu <= 10'd400;
    wr(`TRC_OFS_CTRL, cw(TRC_EXP_PROG, TRC_SUM, 4'b1111));
    expo(r1, l1, r2, l2);
    chk("short", r2 - r1 >= 1874 && r2 - r1 <= 1877, 1);
    run <= 1'b0;
  endtask
  task t_internal;
    wr(`TRC_OFS_PERIOD, 32'd300);
    wr(`TRC_OFS_CTRL, cw(TRC_EXP_PROG, TRC_SINGLE, 4'b0001));
    repeat (700) @(posedge hclk);
    rd(`TRC_OFS_MEAS, "meas", 32'd300);
    rd(`TRC_OFS_INTEG, "integ", 32'd600);
    rd(`TRC_OFS_LINES, "lines", 32'd5);
    wr(`TRC_OFS_CTRL, 32'h0);
  endtask
  initial begin
    repeat (60000) @(posedge hclk);
    failures++;
    summarize;
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`TRC_OFS_CTRL, "ctrl", 32'h0);
    rd(`TRC_OFS_EXPO, "expo", {8'h0, `TRC_EXPO_RST});
    rd(`TRC_OFS_PERIOD, "period", {8'h0, `TRC_PERIOD_RST});
    wr(8'h1c, 32'h0000ffff);
    rd(8'h1c, "unmapped", 32'h0);
    t_2k;
    t_width;
    t_4k;
    t_internal;
    summarize;
  end
endmodule
